// file: bench/bgpd_ctrl_model.sv
// Behavioural model of the external controller or hall sensors.
// Assumes the bench commands it on the same clock as the decoder.
`timescale 1ns/1ps
`default_nettype none
module bgpd_ctrl_model (
  input  wire logic       clock,
  input  wire logic       idle,
  input  wire logic       hallTie,
  input  wire logic       floatUnused,
  input  wire logic [2:0] cmdHigh,
  input  wire logic [2:0] cmdLow,
  output var  logic [2:0] phaseHighInput = 3'h0,
  output var  logic [2:0] phaseLowInput = 3'h0
);
  // ==========================================================================
  // Input drive, changed only right after a rising edge
  always @(posedge clock) begin
    if (idle) begin
      phaseHighInput <= 3'h0;
      phaseLowInput  <= 3'h0;
    end else if (floatUnused) begin
      phaseHighInput <= cmdHigh;
      phaseLowInput  <= 3'h7;
    end else if (hallTie) begin
      phaseHighInput <= {1'b0, cmdHigh[1:0]};
      phaseLowInput  <= {1'b1, cmdLow[1:0]};
    end else begin
      phaseHighInput <= cmdHigh;
      phaseLowInput  <= cmdLow;
    end
  end
endmodule
`default_nettype wire

// file: bench/bgpd_decoder_tb.sv
// Self-checking bench for the gate PWM input decoder.
// Assumes the decoder package and the controller model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module bgpd_decoder_tb;
  logic        clock = 1'b0;
  logic        srst, regWrite, regRead, idle, hallTie, floatUnused, rdSeen = 1'b0;
  logic [1:0]  modeStrap, curMode;
  logic [7:0]  regAddr;
  logic [31:0] regWdata, regRdata, seed;
  logic [2:0]  cmdHigh, cmdLow, phH, phL, gHi, gLo, h, l;
  logic [63:0] expQ[$];
  int          num_errors = 0;
  int          num_checks = 0;

  always #5 clock = ~clock;

  bgpd_ctrl_model u_model (.clock(clock), .idle(idle), .hallTie(hallTie),
    .floatUnused(floatUnused), .cmdHigh(cmdHigh), .cmdLow(cmdLow),
    .phaseHighInput(phH), .phaseLowInput(phL));

  bgpd_decoder u_dut (.clock(clock), .srst(srst), .phaseHighInput(phH),
    .phaseLowInput(phL), .modeStrap(modeStrap), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .phaseHighGate(gHi), .phaseLowGate(gLo));

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] nextRand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Expected {low gates, high gates} with the PWM input held still
  function automatic logic [5:0] gateRef(input logic [1:0] m, input logic fw,
                                         input logic [2:0] hi, input logic [2:0] lo);
    logic [2:0] gh, gl, c, src, snk;
    src = 3'h0;
    snk = 3'h0;
    c = {lo[0], hi[1], lo[1]};
    case (m)
      2'h0: begin gh = hi & ~lo; gl = lo & ~hi; end
      2'h1: begin gh = hi & lo; gl = ~hi & lo; end
      2'h3: begin gh = hi; gl = lo; end
      default: begin
        if (c == 3'h7) {src, snk} = 6'h0e;
        else if (c != 3'h0) begin
          case (hi[2] ? ~c : c)
            3'h6: {src, snk} = 6'h14;
            3'h4: {src, snk} = 6'h0c;
            3'h5: {src, snk} = 6'h0a;
            3'h1: {src, snk} = 6'h22;
            3'h3: {src, snk} = 6'h21;
            default: {src, snk} = 6'h11;
          endcase
        end
        gh = {3{hi[0]}} & src;
        gl = ({3{~hi[0] & ~fw}} & src) | snk;
        if (!lo[2]) begin gh = 3'h0; gl = 3'h7; end
      end
    endcase
    return {gl, gh};
  endfunction

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", what, e, g);
      num_errors++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    regWrite <= 1'b1; regAddr <= a; regWdata <= d;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    expQ.push_back({m, e});
    @(posedge clock);
    regRead <= 1'b1; regAddr <= a;
    @(posedge clock);
    regRead <= 1'b0;
    @(posedge clock);
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ==========================================================================
  // Monitor: read data stands only in the cycle after the read strobe
  always @(posedge clock) begin
    logic [63:0] n;
    if (rdSeen) begin
      n = expQ.pop_front();
      chk("regRdata", n[31:0], regRdata & n[63:32]);
      if (n[63:32] == 32'h3f07) chk("gates", {26'h0, n[13:8]}, {26'h0, gLo, gHi});
    end
    rdSeen <= regRead;
    if (!srst && curMode != 2'h3) chk("overlap", 32'h0, {29'h0, gHi & gLo});
  end

  // ==========================================================================
  // Stimulus
  initial begin
    srst = 1'b1; regWrite = 1'b0; regRead = 1'b0; regAddr = 8'h00; regWdata = 32'h0;
    modeStrap = 2'h2; curMode = 2'h2; idle = 1'b1; hallTie = 1'b0; floatUnused = 1'b0;
    cmdHigh = 3'h0; cmdLow = 3'h0; seed = 32'hfb06;
    repeat (16) @(posedge clock);
    srst <= 1'b0;
    rd(bgpd_pkg::CTRL_ADDR, 32'h8, 32'hf);
    rd(bgpd_pkg::STATUS_ADDR, 32'h2, 32'h3);
    wr(bgpd_pkg::STATUS_ADDR, 32'hffffffff);
    rd(8'h08, 32'h0, 32'hffffffff);
    rd(bgpd_pkg::CTRL_ADDR, 32'h8, 32'hf);
    for (int k = 0; k < 8; k++) begin
      idle <= 1'b1;
      repeat (20) @(posedge clock);
      wr(bgpd_pkg::CTRL_ADDR, {28'h0, 1'b0, k[2], k[1:0]});
      curMode <= k[1:0];
      for (int i = 0; i < 16; i++) begin
        seed = nextRand(seed);
        h = seed[2:0];
        l = seed[5:3];
        if (k[1:0] == 2'h2) begin
          h = {i[3], i[1], seed[0]};
          l = {seed[3] | seed[4], i[0], i[2]};
        end
        cmdHigh <= h;
        cmdLow <= l;
        hallTie <= (k[1:0] == 2'h2) & seed[8] & seed[9];
        floatUnused <= (k[1:0] == 2'h1) & seed[10];
        idle <= 1'b0;
        repeat (20) @(posedge clock);
        rd(bgpd_pkg::STATUS_ADDR, {18'h0, gateRef(k[1:0], k[2], phH, phL), 5'h0, k[2], k[1:0]},
           32'h3f07);
      end
    end
    finish_test();
  end

  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    finish_test();
  end
endmodule
`default_nettype wire

// file: rtl/bgpd_dead_time.sv
// Dead-time stage for one half-bridge: turns requests into gate commands.
// Assumes requests are registered in the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module bgpd_dead_time (
  input  wire logic       clock,
  input  wire logic       srst,
  bgpd_phase_if.driver    ph
);

  typedef enum logic [3:0] {
    ST_OFF  = 4'h1,
    ST_HIGH = 4'h2,
    ST_LOW  = 4'h4,
    ST_DEAD = 4'h8
  } bgpd_dt_state_t;

  bgpd_dt_state_t              state_r, state_nxt;
  logic [bgpd_pkg::CNT_W-1:0]  cnt_r, cnt_nxt;
  logic                        hi_r, hi_nxt;
  logic                        lo_r, lo_nxt;

  // ==========================================================================
  // Next state
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    hi_nxt    = 1'b0;
    lo_nxt    = 1'b0;
    if (ph.bypass) begin
      // Gates follow requests; leaving bypass always passes a full gap
      hi_nxt    = ph.reqHigh;
      lo_nxt    = ph.reqLow;
      state_nxt = ST_DEAD;
      cnt_nxt   = bgpd_pkg::DEAD_LOAD;
    end else begin
      case (state_r)
        ST_OFF: begin
          if (ph.reqHigh && !ph.reqLow) begin
            state_nxt = ST_HIGH;
          end else if (ph.reqLow && !ph.reqHigh) begin
            state_nxt = ST_LOW;
          end
        end
        ST_HIGH: begin
          if (!ph.reqHigh || ph.reqLow) begin
            state_nxt = ST_DEAD;
            cnt_nxt   = bgpd_pkg::DEAD_LOAD;
          end
        end
        ST_LOW: begin
          if (!ph.reqLow || ph.reqHigh) begin
            state_nxt = ST_DEAD;
            cnt_nxt   = bgpd_pkg::DEAD_LOAD;
          end
        end
        ST_DEAD: begin
          if (cnt_r == bgpd_pkg::CNT_ZERO) begin
            state_nxt = ST_OFF;
          end else begin
            cnt_nxt = cnt_r - 1'b1;
          end
        end
        default: begin
          state_nxt = ST_DEAD;
          cnt_nxt   = bgpd_pkg::DEAD_LOAD;
        end
      endcase
      hi_nxt = (state_nxt == ST_HIGH); // [RULE12]
      lo_nxt = (state_nxt == ST_LOW);  // [RULE12]
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state_r <= ST_DEAD;
      cnt_r   <= bgpd_pkg::DEAD_LOAD;
      hi_r    <= 1'b0;
      lo_r    <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      hi_r    <= hi_nxt;
      lo_r    <= lo_nxt;
    end
  end

  assign ph.gateHigh = hi_r;
  assign ph.gateLow  = lo_r;

  // ==========================================================================
  // Checks
  property p_no_overlap;
    @(posedge clock) disable iff (srst)
      !$past(ph.bypass) |-> !(hi_r && lo_r);
  endproperty
  a_no_overlap: assert property (p_no_overlap) // [RULE12]
    else $error("Both gates on outside independent mode");

  property p_gap_after_high;
    @(posedge clock) disable iff (srst)
      ($fell(hi_r) && !ph.bypass) |-> (!lo_r || ph.bypass) [*5];
  endproperty
  a_gap_after_high: assert property (p_gap_after_high) // [RULE12]
    else $error("Low gate turned on inside the dead time");

  property p_bypass_follow;
    @(posedge clock) disable iff (srst)
      ph.bypass |=> (hi_r == $past(ph.reqHigh)) && (lo_r == $past(ph.reqLow));
  endproperty
  a_bypass_follow: assert property (p_bypass_follow) // [RULE15]
    else $error("Independent gates do not follow their requests");

endmodule
`default_nettype wire

// file: rtl/bgpd_decoder.sv
// Gate PWM input decoder: six-, three-, single- and independent-input schemes.
// Assumes inputs synchronous to clock; registers reached over a plain port.
`timescale 1ns/1ps
`default_nettype none

// How it works
// (RULE1) Six-input mode: equal inputs give both gates off, else the one set.
// (RULE2) Three-input mode: low input 0 turns phase off; high input picks gate.
// (RULE3) Controller clears all inputs before changing the drive scheme.
// (RULE4) Single-PWM mode takes the waveform only from the phase-A high input.
// (RULE5) Single-PWM mode reads three state bits from A-low, B-high, B-low.
// (RULE6) Single-PWM mode picks gate patterns from an internal six-step table.
// (RULE7) Direction input high inverts each state code of the table.
// (RULE8) Code 000 stops all gates; code 111 aligns with PWM on phase A.
// (RULE9) Source phase gets PWM and complement, sink low on, third phase off.
// (RULE10) Brake input low turns all high gates off and all low gates on.
// (RULE11) Single-PWM mode is synchronous by default, asynchronous by register bit.
// (RULE12) Dead time always separates the two gates of a phase; the code bypasses it in independent mode.
// (RULE13) Controller ties low inputs high when phase float is unused.
// (RULE14) Controller ties direction low and brake high when unused.
// (RULE15) Independent mode passes each input straight to its gate.
// (RULE16) Asynchronous freewheel holds the PWM phase low gate off.
// (RULE17) Every input passes a two-stage synchroniser before decoding.
module bgpd_decoder (
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic [2:0]  phaseHighInput,
  input  wire logic [2:0]  phaseLowInput,
  input  wire logic [1:0]  modeStrap,
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic [31:0]      regRdata,
  output logic [2:0]       phaseHighGate,
  output logic [2:0]       phaseLowGate
);

  // ==========================================================================
  // Decode functions
  function automatic logic [1:0] pair_decode(input bgpd_pkg::bgpd_mode_t mode,
                                             input logic hi, input logic lo);
    logic [1:0] res;
    res = 2'h0;
    case (mode)
      bgpd_pkg::MODE_SIX:   res = {hi & ~lo, lo & ~hi};        // [RULE1]
      bgpd_pkg::MODE_THREE: res = lo ? {hi, ~hi} : 2'h0;       // [RULE2]
      bgpd_pkg::MODE_INDEP: res = {hi, lo};                    // [RULE15]
      default:              res = 2'h0;
    endcase
    return res;
  endfunction

  // Returns {high[2:0], low[2:0]} for the single-PWM scheme
  function automatic logic [5:0] single_decode(input logic [2:0] code, input logic dir,
                                               input logic pwm, input logic async);
    logic [2:0] src;
    logic [2:0] sink;
    logic [2:0] fwd;
    src  = bgpd_pkg::PH_NONE;
    sink = bgpd_pkg::PH_NONE;
    fwd  = code ^ {3{dir}};                                    // [RULE7]
    if (code == bgpd_pkg::CODE_STOP) begin                     // [RULE8]
      src  = bgpd_pkg::PH_NONE;
      sink = bgpd_pkg::PH_NONE;
    end else if (code == bgpd_pkg::CODE_ALIGN) begin           // [RULE8]
      src  = bgpd_pkg::PH_A;
      sink = bgpd_pkg::PH_B | bgpd_pkg::PH_C;
    end else begin
      case (fwd)                                               // [RULE6] [RULE9]
        bgpd_pkg::CODE_S1: begin src = bgpd_pkg::PH_B; sink = bgpd_pkg::PH_C; end
        bgpd_pkg::CODE_S2: begin src = bgpd_pkg::PH_A; sink = bgpd_pkg::PH_C; end
        bgpd_pkg::CODE_S3: begin src = bgpd_pkg::PH_A; sink = bgpd_pkg::PH_B; end
        bgpd_pkg::CODE_S4: begin src = bgpd_pkg::PH_C; sink = bgpd_pkg::PH_B; end
        bgpd_pkg::CODE_S5: begin src = bgpd_pkg::PH_C; sink = bgpd_pkg::PH_A; end
        bgpd_pkg::CODE_S6: begin src = bgpd_pkg::PH_B; sink = bgpd_pkg::PH_A; end
        default:           begin src = bgpd_pkg::PH_NONE; sink = bgpd_pkg::PH_NONE; end
      endcase
    end
    // Complement on the source low gate only when rectifying synchronously
    return {src & {3{pwm}}, (src & {3{~pwm & ~async}}) | sink}; // [RULE11] [RULE16]
  endfunction

  // ==========================================================================
  // Input synchroniser
  logic [5:0] syncA_r, syncA_nxt;
  logic [5:0] syncB_r, syncB_nxt;

  always_comb begin
    syncA_nxt = {phaseLowInput, phaseHighInput};
    syncB_nxt = syncA_r;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      syncA_r <= 6'h0;
      syncB_r <= 6'h0;
    end else begin
      syncA_r <= syncA_nxt; // [RULE17]
      syncB_r <= syncB_nxt; // [RULE17]
    end
  end

  logic [2:0] hiIn;
  logic [2:0] loIn;
  logic       singlePwm;
  logic [2:0] stateCode;
  logic       directionIn;
  logic       brakeInputN;

  assign hiIn        = syncB_r[2:0];
  assign loIn        = syncB_r[5:3];
  assign singlePwm   = hiIn[0];                      // [RULE4]
  assign stateCode   = {loIn[0], hiIn[1], loIn[1]};  // [RULE5]
  assign directionIn = hiIn[2];
  assign brakeInputN = loIn[2];

  // ==========================================================================
  // Control registers and strap capture
  logic [1:0] ctrlMode_r, ctrlMode_nxt;
  logic       freewheelSelect_r, freewheelSelect_nxt;
  logic       useStrap_r, useStrap_nxt;
  logic [1:0] strapMode_r, strapMode_nxt;
  logic       strapTaken_r, strapTaken_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [2:0]  reqHigh_r, reqHigh_nxt;
  logic [2:0]  reqLow_r, reqLow_nxt;
  logic [2:0]  gateHigh;
  logic [2:0]  gateLow;
  bgpd_pkg::bgpd_mode_t mode;

  assign mode = bgpd_pkg::bgpd_mode_t'(useStrap_r ? strapMode_r : ctrlMode_r);

  always_comb begin
    ctrlMode_nxt        = ctrlMode_r;
    freewheelSelect_nxt = freewheelSelect_r;
    useStrap_nxt        = useStrap_r;
    strapMode_nxt       = strapMode_r;
    strapTaken_nxt      = 1'b1;
    rdata_nxt           = bgpd_pkg::DATA_ZERO;
    if (!strapTaken_r) begin
      strapMode_nxt = modeStrap;
    end
    if (regWrite && regAddr == bgpd_pkg::CTRL_ADDR) begin
      ctrlMode_nxt        = regWdata[bgpd_pkg::CTRL_MODE_LSB +: 2];
      freewheelSelect_nxt = regWdata[bgpd_pkg::CTRL_FREEWHEEL];
      useStrap_nxt        = regWdata[bgpd_pkg::CTRL_USE_STRAP];
    end
    if (regRead) begin
      case (regAddr)
        bgpd_pkg::CTRL_ADDR: begin
          rdata_nxt[bgpd_pkg::CTRL_MODE_LSB +: 2] = ctrlMode_r;
          rdata_nxt[bgpd_pkg::CTRL_FREEWHEEL]     = freewheelSelect_r;
          rdata_nxt[bgpd_pkg::CTRL_USE_STRAP]     = useStrap_r;
        end
        bgpd_pkg::STATUS_ADDR: begin
          rdata_nxt[bgpd_pkg::ST_MODE_LSB +: 2] = mode;
          rdata_nxt[bgpd_pkg::ST_FREEWHEEL]     = freewheelSelect_r;
          rdata_nxt[bgpd_pkg::ST_CODE_LSB +: 3] = stateCode;
          rdata_nxt[bgpd_pkg::ST_DIR]           = directionIn;
          rdata_nxt[bgpd_pkg::ST_BRAKE_N]       = brakeInputN;
          rdata_nxt[bgpd_pkg::ST_HI_LSB +: 3]   = gateHigh;
          rdata_nxt[bgpd_pkg::ST_LO_LSB +: 3]   = gateLow;
        end
        default: rdata_nxt = bgpd_pkg::DATA_ZERO;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      ctrlMode_r        <= bgpd_pkg::CTRL_MODE_RST;
      freewheelSelect_r <= bgpd_pkg::CTRL_FW_RST;  // [RULE11]
      useStrap_r        <= bgpd_pkg::CTRL_STRAP_RST;
      strapMode_r       <= bgpd_pkg::CTRL_MODE_RST;
      strapTaken_r      <= 1'b0;
      rdata_r           <= bgpd_pkg::DATA_ZERO;
    end else begin
      ctrlMode_r        <= ctrlMode_nxt;
      freewheelSelect_r <= freewheelSelect_nxt;
      useStrap_r        <= useStrap_nxt;
      strapMode_r       <= strapMode_nxt;
      strapTaken_r      <= strapTaken_nxt;
      rdata_r           <= rdata_nxt;
    end
  end

  assign regRdata = rdata_r;

  // ==========================================================================
  // Gate requests
  always_comb begin
    logic [1:0] pr;
    logic [5:0] sp;
    pr          = 2'h0;
    sp          = single_decode(stateCode, directionIn, singlePwm, freewheelSelect_r);
    reqHigh_nxt = 3'h0;
    reqLow_nxt  = 3'h0;
    if (mode == bgpd_pkg::MODE_SINGLE) begin
      if (!brakeInputN) begin                          // [RULE10]
        reqHigh_nxt = 3'h0;
        reqLow_nxt  = 3'h7;
      end else begin
        reqHigh_nxt = sp[5:3];
        reqLow_nxt  = sp[2:0];
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        pr             = pair_decode(mode, hiIn[i], loIn[i]);
        reqHigh_nxt[i] = pr[1];
        reqLow_nxt[i]  = pr[0];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      reqHigh_r <= 3'h0;
      reqLow_r  <= 3'h0;
    end else begin
      reqHigh_r <= reqHigh_nxt;
      reqLow_r  <= reqLow_nxt;
    end
  end

  // ==========================================================================
  // Dead-time stages
  for (genvar g = 0; g < 3; g++) begin : g_phase
    bgpd_phase_if phIf ();
    assign phIf.reqHigh = reqHigh_r[g];
    assign phIf.reqLow  = reqLow_r[g];
    assign phIf.bypass  = (mode == bgpd_pkg::MODE_INDEP); // [RULE15]
    assign gateHigh[g]  = phIf.gateHigh;
    assign gateLow[g]   = phIf.gateLow;
    bgpd_dead_time u_dead ( // [RULE12]
      .clock (clock),
      .srst  (srst),
      .ph    (phIf.driver)
    );
  end

  assign phaseHighGate = gateHigh;
  assign phaseLowGate  = gateLow;

  // ==========================================================================
  // Checks
  sequence s_single_run;
    mode == bgpd_pkg::MODE_SINGLE && brakeInputN;
  endsequence

  sequence s_state1;
    s_single_run ##0 ((!directionIn && stateCode == 3'h6) ||
                      (directionIn && stateCode == 3'h1));
  endsequence

  property p_six_equal_off;
    @(posedge clock) disable iff (srst)
      (mode == bgpd_pkg::MODE_SIX && hiIn[0] == loIn[0]) |=> !reqHigh_r[0] && !reqLow_r[0];
  endproperty
  a_six_equal_off: assert property (p_six_equal_off) // [RULE1]
    else $error("Six-input equal inputs did not turn phase A off");

  property p_six_high;
    @(posedge clock) disable iff (srst)
      (mode == bgpd_pkg::MODE_SIX && hiIn[1] && !loIn[1]) |=> reqHigh_r[1] && !reqLow_r[1];
  endproperty
  a_six_high: assert property (p_six_high) // [RULE1]
    else $error("Six-input high request lost on phase B");

  property p_three_float;
    @(posedge clock) disable iff (srst)
      (mode == bgpd_pkg::MODE_THREE && !loIn[2]) |=> !reqHigh_r[2] && !reqLow_r[2];
  endproperty
  a_three_float: assert property (p_three_float) // [RULE2]
    else $error("Three-input low 0 did not float phase C");

  property p_three_low;
    @(posedge clock) disable iff (srst)
      (mode == bgpd_pkg::MODE_THREE && loIn[0] && !hiIn[0]) |=> reqLow_r[0] && !reqHigh_r[0];
  endproperty
  a_three_low: assert property (p_three_low) // [RULE2]
    else $error("Three-input did not pick low gate");

  property p_state1;
    @(posedge clock) disable iff (srst)
      s_state1 |=> reqHigh_r == {1'b0, $past(singlePwm), 1'b0} && reqLow_r[2] && !reqLow_r[0];
  endproperty
  a_state1: assert property (p_state1) // [RULE7] [RULE9]
    else $error("State 1 pattern wrong for B to C");

  property p_stop;
    @(posedge clock) disable iff (srst)
      (s_single_run ##0 stateCode == bgpd_pkg::CODE_STOP) |=> reqHigh_r == 3'h0 && reqLow_r == 3'h0;
  endproperty
  a_stop: assert property (p_stop) // [RULE8]
    else $error("Stop code did not clear all gates");

  property p_brake;
    @(posedge clock) disable iff (srst)
      (mode == bgpd_pkg::MODE_SINGLE && !brakeInputN) |=> reqHigh_r == 3'h0 && reqLow_r == 3'h7;
  endproperty
  a_brake: assert property (p_brake) // [RULE10]
    else $error("Brake did not override the table");

  property p_async_src_low;
    @(posedge clock) disable iff (srst)
      (s_single_run ##0 freewheelSelect_r ##0 stateCode == bgpd_pkg::CODE_ALIGN) |=> !reqLow_r[0];
  endproperty
  a_async_src_low: assert property (p_async_src_low) // [RULE16]
    else $error("Asynchronous freewheel drove the PWM low gate");

  property p_sync_delay;
    @(posedge clock) disable iff (srst)
      (mode == bgpd_pkg::MODE_INDEP) [*3] |-> reqHigh_r == $past(phaseHighInput, 3);
  endproperty
  a_sync_delay: assert property (p_sync_delay) // [RULE17] [RULE15]
    else $error("Independent requests do not trail inputs by three cycles");

endmodule
`default_nettype wire

// file: rtl/bgpd_phase_if.sv
// Per-phase carrier between the decoder and its dead-time stage.
// Assumes both ends share one clock.
`timescale 1ns/1ps
`default_nettype none
interface bgpd_phase_if;
  logic reqHigh;
  logic reqLow;
  logic bypass;
  logic gateHigh;
  logic gateLow;

  modport source (output reqHigh, output reqLow, output bypass,
                  input gateHigh, input gateLow);
  modport driver (input reqHigh, input reqLow, input bypass,
                  output gateHigh, output gateLow);
endinterface
`default_nettype wire

// file: rtl/bgpd_pkg.sv
// Shared constants and types for the gate PWM input decoder.
// Assumes a single 100 MHz clock and a synchronous active-high reset.
package bgpd_pkg;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int DEAD_TIME_NS  = 50;
  // Least time: round up to whole cycles, never below one
  localparam int DEAD_CYCLES_RAW = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEAD_CYCLES     = (DEAD_CYCLES_RAW < 1) ? 1 : DEAD_CYCLES_RAW;
  localparam int CNT_W           = 4;
  localparam logic [CNT_W-1:0] DEAD_LOAD = CNT_W'(DEAD_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO  = 4'h0;

  // ==========================================================================
  // Drive schemes
  typedef enum logic [1:0] {
    MODE_SIX    = 2'h0,
    MODE_THREE  = 2'h1,
    MODE_SINGLE = 2'h2,
    MODE_INDEP  = 2'h3
  } bgpd_mode_t;

  // ==========================================================================
  // Commutation state codes {stateBitA, stateBitB, stateBitC}, forward direction
  localparam logic [2:0] CODE_STOP  = 3'h0;
  localparam logic [2:0] CODE_ALIGN = 3'h7;
  localparam logic [2:0] CODE_S1    = 3'h6;
  localparam logic [2:0] CODE_S2    = 3'h4;
  localparam logic [2:0] CODE_S3    = 3'h5;
  localparam logic [2:0] CODE_S4    = 3'h1;
  localparam logic [2:0] CODE_S5    = 3'h3;
  localparam logic [2:0] CODE_S6    = 3'h2;
  // Phase masks: bit0 = A, bit1 = B, bit2 = C
  localparam logic [2:0] PH_NONE = 3'h0;
  localparam logic [2:0] PH_A    = 3'h1;
  localparam logic [2:0] PH_B    = 3'h2;
  localparam logic [2:0] PH_C    = 3'h4;

  // ==========================================================================
  // Register map
  localparam int          ADDR_W      = 8;
  localparam int          DATA_W      = 32;
  localparam logic [7:0]  CTRL_ADDR   = 8'h00;
  localparam logic [7:0]  STATUS_ADDR = 8'h04;
  localparam int          CTRL_MODE_LSB  = 0;
  localparam int          CTRL_FREEWHEEL = 2;
  localparam int          CTRL_USE_STRAP = 3;
  localparam logic [1:0]  CTRL_MODE_RST  = 2'h0;
  localparam logic        CTRL_FW_RST    = 1'b0;
  localparam logic        CTRL_STRAP_RST = 1'b1;
  localparam int          ST_MODE_LSB    = 0;
  localparam int          ST_FREEWHEEL   = 2;
  localparam int          ST_CODE_LSB    = 3;
  localparam int          ST_DIR         = 6;
  localparam int          ST_BRAKE_N     = 7;
  localparam int          ST_HI_LSB      = 8;
  localparam int          ST_LO_LSB      = 11;
  localparam logic [31:0] DATA_ZERO      = 32'h0;

endpackage
